// file: ddsc_core.sv
`timescale 1ns/1ns
// Functional notes
// - Sine when control bit 16 set, else cosine.
// - Phase advances by step word each clock.
// - Step words above half wrap, never clamped.
// - Phase shift word added before amplitude conversion.
// - Converted sample scaled by scale word over 4096.
// - Modulation values accepted once per 16 clocks.
// - Calibration lasts 469,632 sample clocks.
// - Sync mode adds 16 sync clock periods.
// - Multiplier enable selects system clock source.
// - One 12-bit sample per clock to converter.
// - Parallel data clock at one sixteenth rate.
module ddsc_core
  import ddsc_pkg::*;
#(
  parameter int unsigned CAL_LEN  = CAL_CYCLES,
  parameter int unsigned SYNC_LEN = SYNC_CAL_PERIODS,
  parameter int unsigned LUT_W    = 8
) (
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  // Control words.
  input  wire ddsc_tune_t        tuneIn,
  input  wire logic              sineSel,
  input  wire logic              modEnable,
  input  wire logic              calTrigger,
  input  wire logic              syncMode,
  input  wire logic              syncClkIn,
  input  wire logic              pllEnable,
  // Clock source selection.
  output logic                   useMultClk,
  // Converter side.
  output logic [AMP_W-1:0]       dacSample,
  output logic                   dataClk,
  output logic                   calBusy,
  output logic                   calDone
);
  initial begin
    if (CAL_LEN < 1 || CAL_LEN > 32'h00FFFFFF) $error("CAL_LEN out of range");
    if (SYNC_LEN < 1 || SYNC_LEN > 255) $error("SYNC_LEN out of range");
    if (LUT_W < 4 || LUT_W > 14) $error("LUT_W out of range");
    if (MOD_DIV != 16) $error("MOD_DIV must match the four-bit divider");
  end

  ddsc_tune_t             tune_ff;
  logic [3:0]             modDiv_ff;
  logic                   modSlot;
  logic [PHASE_W-1:0]     phaseAcc_ff;
  logic [PHASE_OFS_W-1:0] angle_ff;
  logic signed [AMP_W-1:0] lutSample;
  logic signed [AMP_W+SCALE_W:0] scaled;
  logic [AMP_W-1:0]       dacSample_ff;
  logic                   dataClk_ff;

  // Divider for the modulation slot and the parallel data clock.
  // It runs free from reset, so the slot and the data clock keep a fixed relation.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      modDiv_ff <= 4'h0;
    end else begin
      modDiv_ff <= modDiv_ff + 4'h1;
    end
  end
  assign modSlot = (modDiv_ff == 4'(MOD_DIV - 1));

  // Registered so that the pin never shows decode glitches of the counter.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dataClk_ff <= 1'b0;
    end else begin
      dataClk_ff <= modDiv_ff[3];
    end
  end
  assign dataClk = dataClk_ff;

  // Control words latch each clock when static, once per slot when modulated.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tune_ff <= '{freqStep: '0, phaseShift: '0, ampScale: SCALE_RST};
    end else if (!modEnable || modSlot) begin
      tune_ff <= tuneIn;
    end
  end

  // Accumulator wraps modulo 2^32 with no clamp of the step word.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      phaseAcc_ff <= '0;
    end else begin
      phaseAcc_ff <= phaseAcc_ff + tune_ff.freqStep;
    end
  end

  // Cosine is sine advanced by a quarter turn.
  logic [PHASE_OFS_W-1:0] phaseTop;
  logic [PHASE_OFS_W-1:0] quadOfs;

  // Only the top bits reach the table; the lower bits keep the fine frequency steps.
  assign phaseTop = phaseAcc_ff[PHASE_W-1 -: PHASE_OFS_W];
  assign quadOfs  = sineSel ? 16'h0000 : 16'h4000;

  // The offset wraps modulo a full turn, as the phase itself does.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      angle_ff <= '0;
    end else begin
      angle_ff <= phaseTop + tune_ff.phaseShift + quadOfs;
    end
  end

  ddsc_sine_lut #(.IDX_W(LUT_W)) uLut (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .angle   (angle_ff),
    .sample  (lutSample)
  );

  // The scale word is zero-extended so that 12'hFFF stays a gain just below one.
  logic signed [SCALE_W:0] scaleSigned;

  assign scaleSigned = $signed({1'b0, tune_ff.ampScale});
  assign scaled      = lutSample * scaleSigned;

  // Dropping twelve bits divides by 4096 and keeps the product inside twelve bits.
  // Flipping the sign bit turns two's complement into the converter's offset binary.
  logic [AMP_W-1:0] offsetCode;

  assign offsetCode = {~scaled[AMP_W+SCALE_W-1], scaled[AMP_W+SCALE_W-2 -: AMP_W-1]};

  // One sample per clock to the converter.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dacSample_ff <= 12'h800;
    end else begin
      dacSample_ff <= offsetCode;
    end
  end
  assign dacSample = dacSample_ff;

  assign useMultClk = pllEnable;

  // Calibration sequencer started by the rising edge of the trigger bit.
  ddsc_cal_t   calState_ff;
  logic [23:0] calCnt_ff;
  logic [7:0]  syncCnt_ff;
  logic        calTrig_ff;
  logic        syncPrev_ff;
  logic        calDone_ff;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      calTrig_ff  <= 1'b0;
      syncPrev_ff <= 1'b0;
    end else begin
      calTrig_ff  <= calTrigger;
      syncPrev_ff <= syncClkIn;
    end
  end

  logic calStart;
  logic calRunEnd;
  logic syncRise;
  logic syncEnd;

  // A trigger left high does not restart a finished run: only a fresh 0-to-1 step counts.
  assign calStart  = calTrigger && !calTrig_ff;
  assign calRunEnd = (calCnt_ff == 24'(CAL_LEN - 1));

  // The sync clock is slow against the system clock, so it is sampled as data.
  assign syncRise = syncClkIn && !syncPrev_ff;
  assign syncEnd  = (syncCnt_ff == 8'(SYNC_LEN - 1));

  // The done flag stays up until the next run starts, so software may poll it late.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      calState_ff <= CAL_IDLE;
      calCnt_ff   <= '0;
      syncCnt_ff  <= '0;
      calDone_ff  <= 1'b0;
    end else begin
      unique case (calState_ff)
        CAL_IDLE: begin
          if (calStart) begin
            calState_ff <= CAL_RUN;
            calCnt_ff   <= '0;
            calDone_ff  <= 1'b0;
          end
        end
        CAL_RUN: begin
          if (calRunEnd) begin
            syncCnt_ff  <= '0;
            calState_ff <= syncMode ? CAL_SYNC : CAL_IDLE;
            calDone_ff  <= !syncMode;
          end else begin
            calCnt_ff <= calCnt_ff + 24'h1;
          end
        end
        CAL_SYNC: begin
          if (syncRise) begin
            if (syncEnd) begin
              calState_ff <= CAL_IDLE;
              calDone_ff  <= 1'b1;
            end else begin
              syncCnt_ff <= syncCnt_ff + 8'h1;
            end
          end
        end
        default: calState_ff <= CAL_IDLE;
      endcase
    end
  end

  assign calBusy = (calState_ff != CAL_IDLE);
  assign calDone = calDone_ff;
endmodule

// file: ddsc_pkg.sv
package ddsc_pkg;
  localparam int unsigned PHASE_W      = 32;
  localparam int unsigned PHASE_OFS_W  = 16;
  localparam int unsigned AMP_W        = 12;
  localparam int unsigned SCALE_W      = 12;
  localparam int unsigned CTRL0_SINE_BIT   = 16;
  localparam int unsigned CTRL3_CAL_BIT    = 24;
  localparam int unsigned MOD_DIV          = 16;
  localparam int unsigned CAL_CYCLES       = 469632;
  localparam int unsigned SYNC_CAL_PERIODS = 16;
  localparam int unsigned SYS_CLK_HZ       = 25000000;
  localparam logic [SCALE_W-1:0] SCALE_RST = 12'hFFF;

  typedef struct packed {
    logic [PHASE_W-1:0]     freqStep;
    logic [PHASE_OFS_W-1:0] phaseShift;
    logic [SCALE_W-1:0]     ampScale;
  } ddsc_tune_t;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN  = 2'b01,
    CAL_SYNC = 2'b10
  } ddsc_cal_t;
endpackage

// file: ddsc_sine_lut.sv
`timescale 1ns/1ns
module ddsc_sine_lut
  import ddsc_pkg::*;
#(
  parameter int unsigned IDX_W = 8
) (
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  // Angle in, signed sample out one cycle later.
  input  wire logic [PHASE_OFS_W-1:0] angle,
  output logic signed [AMP_W-1:0]     sample
);
  initial begin
    if (IDX_W < 4 || IDX_W > 14) $error("IDX_W out of range");
  end

  localparam int unsigned DEPTH = 1 << IDX_W;
  logic [AMP_W-2:0] quarterRom [DEPTH];
  logic [IDX_W-1:0] idx;
  logic             negHalf;
  logic [AMP_W-2:0] mag;

  // Quarter-wave table, filled at time zero with truncated sine values.
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      quarterRom[i] = (AMP_W-1)'($rtoi(2047.0 * $sin(3.14159265358979 * (real'(i) + 0.5) / (2.0 * DEPTH))));
    end
  end

  always_comb begin
    idx = angle[PHASE_OFS_W-2] ? ~angle[PHASE_OFS_W-3 -: IDX_W] : angle[PHASE_OFS_W-3 -: IDX_W];
    negHalf = angle[PHASE_OFS_W-1];
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mag <= '0;
    end else begin
      mag <= quarterRom[idx];
    end
  end

  logic negHalf_ff;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      negHalf_ff <= 1'b0;
    end else begin
      negHalf_ff <= negHalf;
    end
  end

  assign sample = negHalf_ff ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
endmodule

// file: ddsc_core_checker.sv
`timescale 1ns/1ns
module ddsc_core_checker
  import ddsc_pkg::*;
#(
  parameter int unsigned CAL_LEN  = CAL_CYCLES,
  parameter int unsigned SYNC_LEN = SYNC_CAL_PERIODS
) (
  // Clock, reset and control inputs.
  input wire logic             clk_sys, arst_n, sineSel, modEnable, calTrigger, syncMode, syncClkIn, pllEnable,
  input wire ddsc_tune_t       tuneIn,
  // Outputs under watch.
  input wire logic             useMultClk, dataClk, calBusy, calDone,
  input wire logic [AMP_W-1:0] dacSample
);
  localparam int CL = CAL_LEN;
  logic [31:0] busyCnt_ff;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Counts sampled busy cycles; a full-length run is far beyond what a delay may span.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busyCnt_ff <= '0;
    end else if (calBusy) begin
      busyCnt_ff <= busyCnt_ff + 32'h1;
    end else begin
      busyCnt_ff <= '0;
    end
  end
  sequence s_cal_run;
    calBusy && !syncMode && busyCnt_ff == 32'(CL - 1);
  endsequence
  sequence s_sync_run;
    calBusy && syncMode && busyCnt_ff == 32'(CL - 1);
  endsequence
  sequence s_quiet;
    (tuneIn.freqStep == 32'h0 && !modEnable && $stable(tuneIn) && $stable(sineSel) && $stable(calBusy))[*6];
  endsequence
  a_clk_src_sel: assert property (useMultClk == pllEnable) else $error("clock source select wrong");
  a_cal_starts: assert property ($rose(calTrigger) && !calBusy |=> calBusy) else $error("calibration not started");
  a_cal_length: assert property (s_cal_run |=> (!calBusy && calDone)) else $error("calibration length wrong");
  a_cal_early: assert property (calBusy && busyCnt_ff < 32'(CL - 1) |=> calBusy) else $error("calibration cut short");
  a_sync_extend: assert property (s_sync_run |=> calBusy) else $error("sync not extended");
  a_done_clears: assert property ($rose(calBusy) |=> !calDone) else $error("done flag not cleared");
  a_dclk_duty: assert property ($rose(dataClk) |-> dataClk[*8] ##1 !dataClk[*8]) else $error("data clock shape");
  a_dc_steady: assert property (s_quiet |-> $stable(dacSample)) else $error("sample moved at zero step");
  a_rst_sample: assert property ($rose(arst_n) |-> dacSample == 12'h800 && !calBusy) else $error("reset sample");
endmodule
bind ddsc_core ddsc_core_checker #(.CAL_LEN(CAL_LEN), .SYNC_LEN(SYNC_LEN)) ddsc_core_checker_inst (.*);

// file: ddsc_dac_model.sv
`timescale 1ns/1ns
module ddsc_dac_model
  import ddsc_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic [AMP_W-1:0] dacSample,
  output logic      [AMP_W-1:0] lastCode
);
  // The converter latches one code on every sample clock.
  always_ff @(posedge clk_sys) begin
    lastCode <= dacSample;
  end
endmodule

// file: testbench.sv
`timescale 1ns/1ns
module testbench;
  import ddsc_pkg::*;
  localparam int CAL = 20;
  logic             clk_sys, arst_n, sineSel, modEnable, calTrigger, syncMode, syncClkIn, pllEnable, syncRun;
  logic             useMultClk, dataClk, calBusy, calDone;
  ddsc_tune_t       tuneIn;
  logic [AMP_W-1:0] dacSample, lastCode;
  int               error_cnt, comparisons;
  ddsc_core #(.CAL_LEN(CAL), .SYNC_LEN(2)) ddsc_core_inst (.*);
  ddsc_dac_model ddsc_dac_model_inst (.*);
  task automatic chk(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic near(input logic [11:0] got, exp);
    chk((got > exp ? got - exp : exp - got) <= 12'h020 && !$isunknown(got) ? got : ~got, got);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic setw(input logic [31:0] f, input logic [15:0] p, input logic [11:0] a, input logic s);
    cyc(1);
    tuneIn = '{f, p, a};
    sineSel = s;
  endtask
  task automatic t_tone();
    logic [15:0] ph[6] = '{16'h0, 16'h4000, 16'h0, 16'h8000, 16'hC000, 16'h0};
    logic [11:0] am[6] = '{12'hFFF, 12'hFFF, 12'hFFF, 12'hFFF, 12'hFFF, 12'h800};
    logic [11:0] ex[6] = '{12'h800, 12'hFFE, 12'hFFE, 12'h800, 12'h002, 12'hBFF};
    for (int i = 0; i < 6; i++) begin
      setw(32'h0, ph[i], am[i], i != 2 && i != 5);
      cyc(10);
      near(lastCode, ex[i]);
    end
  endtask
  task automatic t_step(input logic [31:0] f);
    logic [11:0] s[5];
    setw(f, 16'h0, 12'hFFF, 1'b0);
    cyc(8);
    foreach (s[i]) begin
      s[i] = lastCode;
      cyc(1);
    end
    near(12'((13'(s[0]) + 13'(s[2])) >> 1), 12'h800);
    near(12'((13'(s[1]) + 13'(s[3])) >> 1), 12'h800);
    chk(s[4], s[0]);
  endtask
  task automatic t_mod(input logic m, input int lo, hi);
    int n;
    logic [11:0] prev;
    n = 0;
    modEnable = m;
    prev = lastCode;
    // Counting starts once the pipeline is full; the phase flips each clock, and flips
    // again every 16 clocks so that two successive modulation slots never take the same value.
    for (int i = 0; i < 40; i++) begin
      setw(32'h0, (i[0] ^ i[4]) ? 16'h0 : 16'h8000, 12'hFFF, 1'b0);
      n += (i >= 8) && (lastCode !== prev);
      prev = lastCode;
    end
    chk(n >= lo && n <= hi, 1);
    modEnable = 1'b0;
    cyc(20);
  endtask
  task automatic t_cal(input logic sm, input int lo, hi);
    int n;
    n = 0;
    syncMode = sm;
    syncRun = sm;
    calTrigger = 1'b1;
    for (int i = 0; i < 100; i++) begin
      cyc(1);
      calTrigger = (i >= 5 && i < 7);
      n += calBusy;
    end
    chk(n >= lo && n <= hi, 1);
    chk(calDone, 1'b1);
    syncRun = 1'b0;
  endtask
  task automatic t_dclk();
    logic [31:0] v;
    for (int i = 0; i < 32; i++) begin
      cyc(1);
      v[i] = dataClk;
    end
    chk(v[31:16], v[15:0]);
    chk(v[7:0] ^ v[15:8], 8'hFF);
  endtask
  task automatic results();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // The sync clock is idle between calibrations that do not use it.
  initial begin
    syncClkIn = 1'b0;
    forever begin
      cyc(4);
      syncClkIn = syncRun & ~syncClkIn;
    end
  end
  initial begin
    #400000;
    error_cnt++;
    results();
  end
  initial begin
    {arst_n, sineSel, modEnable, calTrigger, syncMode, pllEnable, syncRun} = '0;
    tuneIn = '{32'h0, 16'h0, 12'hFFF};
    cyc(16);
    chk(dacSample, 12'h800);
    chk(calDone, 1'b0);
    for (int i = 0; i < 2; i++) begin
      pllEnable = i[0];
      cyc(1);
      chk(useMultClk, pllEnable);
    end
    arst_n = 1'b1;
    t_tone();
    t_step(32'h4000_0000);
    t_step(32'hC000_0000);
    setw(32'h0, 16'h0, 12'hFFF, 1'b0);
    t_mod(1'b0, 28, 32);
    t_mod(1'b1, 1, 3);
    t_cal(1'b0, CAL, CAL);
    t_cal(1'b1, CAL + 1, CAL + 20);
    t_dclk();
    results();
  end
endmodule
